//--- inc/pdld_pkg.sv
/*
 * pdld_pkg: register offsets, field positions, reset values and timing
 * constants for the phase detector lock-detect control block.
 * Assumes a plain strobe register port and a 250 MHz system clock.
 */
package pdld_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 24;
    // register offsets
    localparam logic [7:0]  OFS_LOCK_CFG  = 8'h07;
    localparam logic [7:0]  OFS_CP_GAIN   = 8'h09;
    localparam logic [7:0]  OFS_PD_CFG    = 8'h0B;
    localparam logic [7:0]  OFS_STATUS    = 8'h12;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h13;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
    // lock_detect_config fields
    localparam int          LK_CNT_LO     = 0;
    localparam int          LK_CNT_HI     = 2;
    localparam int          LK_EN_BIT     = 3;
    localparam int          LK_WTYPE_BIT  = 6;
    localparam int          LK_DIV_LO     = 7;
    localparam int          LK_DIV_HI     = 9;
    localparam int          LK_SPD_LO     = 10;
    localparam int          LK_SPD_HI     = 11;
    // charge_pump_gain_offset fields
    localparam int          CP_DN_LO      = 0;
    localparam int          CP_DN_HI      = 6;
    localparam int          CP_UP_LO      = 7;
    localparam int          CP_UP_HI      = 13;
    localparam int          CP_OFS_LO     = 14;
    localparam int          CP_OFS_HI     = 20;
    localparam int          CP_OFS_UP_BIT = 21;
    localparam int          CP_OFS_DN_BIT = 22;
    // phase_detector_config fields
    localparam int          PD_POL_BIT    = 4;
    localparam int          PD_UPEN_BIT   = 5;
    localparam int          PD_DNEN_BIT   = 6;
    localparam int          PD_CSP_LO     = 7;
    localparam int          PD_CSP_HI     = 8;
    // reset values
    localparam logic [23:0] LOCK_CFG_RST  = 24'h00_0000;
    localparam logic [23:0] CP_GAIN_RST   = 24'h00_0000;
    localparam logic [23:0] PD_CFG_RST    = 24'h00_0060;
    // interrupt bits
    localparam int          IRQ_LOCK_BIT  = 0;
    localparam int          IRQ_UNLK_BIT  = 1;
    localparam int          IRQ_W         = 2;
    // timing: fastest timer tick 2 clocks, each speed code adds one
    localparam int          TICK_BASE     = 2;
    localparam int          TICK_W        = 4;
    // analog window equivalent, 10 ns
    localparam int          AWIN_NS       = 10;
    localparam int          CLK_NS        = 4;
    localparam int          AWIN_CYC      = AWIN_NS / CLK_NS;
    localparam int          WIN_W         = 8;
    localparam int          LKCNT_W       = 14;
    localparam int          LKCNT_BASE    = 64;
    // cycle-slip thresholds in clocks per code
    localparam int          CSP_STEP      = 4;

    typedef enum logic [2:0] {
        WS_IDLE = 3'b001,
        WS_OPEN = 3'b010,
        WS_DONE = 3'b100
    } win_state_t;
endpackage

//--- inc/pdld_if.sv
/*
 * pdld_if: carries window requests and the in-window result between the
 * lock-detect top and its window timer.
 * Assumes one clock shared by both modules.
 */
`timescale 1ns/10ps
interface pdld_if;
    logic       start;      // window opens this cycle
    logic       second;     // second edge seen
    logic [1:0] speed;      // timer speed code
    logic [2:0] div;        // divider code
    logic       dig;        // digital window chosen
    logic       hit;        // pulse: second edge inside window
    logic       miss;       // pulse: window expired first
    logic       open;       // window currently open
    modport top (output start, second, speed, div, dig, input hit, miss, open);
    modport tmr (input start, second, speed, div, dig, output hit, miss, open);
endinterface

//--- logic/pdld_sync.sv
/*
 * pdld_sync: two-flop synchroniser with a rising edge pulse taken from the
 * second and a third flop.
 * Assumes an asynchronous pin input.
 */
`timescale 1ns/10ps
module pdld_sync (
    input  wire logic clk,      // system clock
    input  wire logic resetn,   // async reset, low active
    input  wire logic din,      // pin level
    output logic      rise      // one-cycle rising edge pulse
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // two-flop capture then delay for edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign rise = s2_r & ~s3_r;
endmodule

//--- logic/pdld_window.sv
/*
 * pdld_window: one-shot lock-detect window timer built from a tick divider
 * and a period counter.
 * Assumes edge pulses already synchronised to clk.
 */
`timescale 1ns/10ps
module pdld_window
    import pdld_pkg::*;
(
    input  wire logic clk,      // system clock
    input  wire logic resetn,   // async reset, low active
    pdld_if.tmr       w         // window control
);
    win_state_t         st_r;
    logic [TICK_W-1:0]  tick_r;
    logic [WIN_W-1:0]   cnt_r;
    logic [WIN_W-1:0]   len;
    logic [TICK_W-1:0]  tick_max;
    logic               tick;
    logic               expire;

    assign tick_max = TICK_W'(TICK_BASE + int'(w.speed) - 1);
    assign tick     = (tick_r == tick_max);
    // code 0 gives half a period
    assign len      = WIN_W'(1) << w.div;
    assign expire   = w.dig ? (tick && cnt_r >= len - WIN_W'(1))
                            : (cnt_r >= WIN_W'(AWIN_CYC - 1));

    // half-period tick divider, runs while open
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_r <= '0;
        end else if (st_r != WS_OPEN || tick) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + TICK_W'(1);
        end
    end

    // window state and period counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r  <= WS_IDLE;
            cnt_r <= '0;
        end else begin
            case (st_r)
                WS_IDLE: begin
                    cnt_r <= '0;
                    if (w.start) begin
                        st_r <= WS_OPEN;
                    end
                end
                WS_OPEN: begin
                    if (w.second || expire) begin
                        st_r <= WS_DONE;
                    end else if (!w.dig || tick) begin
                        cnt_r <= cnt_r + WIN_W'(1);
                    end
                end
                WS_DONE: st_r <= WS_IDLE;
                default: st_r <= WS_IDLE;
            endcase
        end
    end

    // result pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w.hit  <= 1'b0;
            w.miss <= 1'b0;
        end else begin
            w.hit  <= (st_r == WS_OPEN) && w.second;
            w.miss <= (st_r == WS_OPEN) && !w.second && expire;
        end
    end

    assign w.open = (st_r == WS_OPEN);
endmodule

//--- logic/pd_lock_detect_control.sv
/*
 * pd_lock_detect_control: register file, lock-detect sequencer, cycle-slip
 * guard and charge pump control outputs around a phase detector.
 * Assumes reference and divided-VCO edges arrive as asynchronous pin levels
 * and a plain strobe register port on clk at 250 MHz.
 */
// Contract
// - two-bit timer speed, 00 fastest, 11 slowest
// - three-bit divider gives 0.5 to 64 timer periods of window
// - window opens on whichever phase detector edge comes first
// - cycle-slip guard boosts gain above threshold set by bits 8:7
// - detector bit 4 inverts phase detector polarity
// - both pump enables cleared tri-states the charge pump
// - two seven-bit pump gain fields, 20 uA per step
// - seven-bit offset magnitude, bit 21 up offset, bit 22 down
// - window-type bit 6 picks analog fixed or digital window
// - bits 2:0 set consecutive in-window count before lock
// - one miss drops lock until count met again
// - lock detection only while enable bit 3 is set
`timescale 1ns/10ps
module pd_lock_detect_control
    import pdld_pkg::*;
(
    input  wire logic              clk,           // 250 MHz clock
    input  wire logic              resetn,        // async reset, low active
    input  wire logic [ADDR_W-1:0] addr,          // register address
    input  wire logic [DATA_W-1:0] wdata,         // write data
    input  wire logic              wr,            // write strobe
    input  wire logic              rd,            // read strobe
    output logic      [DATA_W-1:0] rdata,         // read data, cycle after rd
    input  wire logic              ref_edge,      // reference divider output pin
    input  wire logic              vco_edge,      // divided VCO pin
    output logic                   lock_flag,     // lock detect flag
    output logic                   pump_up,       // pump up command
    output logic                   pump_dn,       // pump down command
    output logic                   pump_hiz,      // charge pump tri-stated
    output logic      [6:0]        pump_up_gain,  // up gain code, 20 uA steps
    output logic      [6:0]        pump_dn_gain,  // down gain code, 20 uA steps
    output logic      [6:0]        ofs_mag,       // offset magnitude code
    output logic                   ofs_up_en,     // up offset enabled
    output logic                   ofs_dn_en,     // down offset enabled
    output logic                   cycle_slip_guard, // gain boost active
    output logic                   irq            // level interrupt
);
    logic [DATA_W-1:0] lock_detect_config_r;
    logic [DATA_W-1:0] charge_pump_gain_offset_r;
    logic [DATA_W-1:0] phase_detector_config_r;
    logic [IRQ_W-1:0]  irq_stat_r;
    logic [IRQ_W-1:0]  irq_mask_r;
    logic [IRQ_W-1:0]  irq_set;
    logic [LKCNT_W-1:0] lk_cnt_r;
    logic [LKCNT_W-1:0] lk_target;
    logic              lock_r;
    logic              ref_rise;
    logic              vco_rise;
    logic              ref_first_r;
    logic [WIN_W-1:0]  err_cnt_r;
    logic [WIN_W-1:0]  csp_thr;
    logic              up_raw;
    logic              dn_raw;
    logic              ld_en;

    pdld_if w ();

    // pin edges through two flops
    pdld_sync u_ref (
        .clk    (clk),
        .resetn (resetn),
        .din    (ref_edge),
        .rise   (ref_rise)
    );
    pdld_sync u_vco (
        .clk    (clk),
        .resetn (resetn),
        .din    (vco_edge),
        .rise   (vco_rise)
    );

    pdld_window u_win (
        .clk    (clk),
        .resetn (resetn),
        .w      (w)
    );

    assign ld_en    = lock_detect_config_r[LK_EN_BIT];
    assign w.start  = ld_en && !w.open && (ref_rise || vco_rise);
    assign w.second = w.open && (ref_first_r ? vco_rise : ref_rise);
    assign w.speed  = lock_detect_config_r[LK_SPD_HI:LK_SPD_LO];
    assign w.div    = lock_detect_config_r[LK_DIV_HI:LK_DIV_LO];
    assign w.dig    = lock_detect_config_r[LK_WTYPE_BIT];

    // remember which edge opened the window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_first_r <= 1'b0;
        end else if (w.start) begin
            ref_first_r <= ref_rise;
        end
    end

    // target is 64 shifted by code
    assign lk_target = LKCNT_W'(LKCNT_BASE) << lock_detect_config_r[LK_CNT_HI:LK_CNT_LO];

    // consecutive hit counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lk_cnt_r <= '0;
        end else if (!ld_en) begin
            lk_cnt_r <= '0;
        end else if (w.miss) begin
            lk_cnt_r <= '0;
        end else if (w.hit && lk_cnt_r < lk_target) begin
            lk_cnt_r <= lk_cnt_r + LKCNT_W'(1);
        end
    end

    // lock flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_r <= 1'b0;
        end else if (!ld_en || w.miss) begin
            lock_r <= 1'b0;
        end else if (w.hit && lk_cnt_r + LKCNT_W'(1) >= lk_target) begin
            lock_r <= 1'b1;
        end
    end

    // phase error timer for cycle-slip guard
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_cnt_r <= '0;
        end else if (!w.open) begin
            err_cnt_r <= '0;
        end else if (err_cnt_r != '1) begin
            err_cnt_r <= err_cnt_r + WIN_W'(1);
        end
    end

    assign csp_thr = WIN_W'(CSP_STEP) *
                     (WIN_W'(phase_detector_config_r[PD_CSP_HI:PD_CSP_LO]) + WIN_W'(1));

    // raw detector direction: ref first means pump up
    assign up_raw = w.open && ref_first_r;
    assign dn_raw = w.open && !ref_first_r;

    // pump and guard outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pump_up          <= 1'b0;
            pump_dn          <= 1'b0;
            pump_hiz         <= 1'b1;
            cycle_slip_guard <= 1'b0;
        end else begin
            pump_up <= phase_detector_config_r[PD_UPEN_BIT] &&
                       (phase_detector_config_r[PD_POL_BIT] ? dn_raw : up_raw);
            pump_dn <= phase_detector_config_r[PD_DNEN_BIT] &&
                       (phase_detector_config_r[PD_POL_BIT] ? up_raw : dn_raw);
            pump_hiz <= !phase_detector_config_r[PD_UPEN_BIT] &&
                        !phase_detector_config_r[PD_DNEN_BIT];
            cycle_slip_guard <= w.open && (err_cnt_r >= csp_thr);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pump_dn_gain <= '0;
            pump_up_gain <= '0;
            ofs_mag      <= '0;
            ofs_up_en    <= 1'b0;
            ofs_dn_en    <= 1'b0;
        end else begin
            pump_dn_gain <= charge_pump_gain_offset_r[CP_DN_HI:CP_DN_LO];
            pump_up_gain <= charge_pump_gain_offset_r[CP_UP_HI:CP_UP_LO];
            ofs_mag      <= charge_pump_gain_offset_r[CP_OFS_HI:CP_OFS_LO];
            ofs_up_en    <= charge_pump_gain_offset_r[CP_OFS_UP_BIT];
            ofs_dn_en    <= charge_pump_gain_offset_r[CP_OFS_DN_BIT];
        end
    end

    // configuration register writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_detect_config_r      <= LOCK_CFG_RST;
            charge_pump_gain_offset_r <= CP_GAIN_RST;
            phase_detector_config_r   <= PD_CFG_RST;
            irq_mask_r                <= '0;
        end else if (wr) begin
            case (addr)
                OFS_LOCK_CFG: lock_detect_config_r      <= wdata;
                OFS_CP_GAIN:  charge_pump_gain_offset_r <= wdata;
                OFS_PD_CFG:   phase_detector_config_r   <= wdata;
                OFS_IRQ_MASK: irq_mask_r                <= wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // lock gained and lock lost events
    assign irq_set[IRQ_LOCK_BIT] = w.hit && !lock_r && ld_en && !w.miss &&
                                   (lk_cnt_r + LKCNT_W'(1) >= lk_target);
    assign irq_set[IRQ_UNLK_BIT] = lock_r && (w.miss || !ld_en);

    // sticky status, set wins over write-one clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r &
                           ~((wr && addr == OFS_IRQ_STAT) ? wdata[IRQ_W-1:0] : '0))
                          | irq_set;
        end
    end

    // read data and level outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata     <= '0;
            lock_flag <= 1'b0;
            irq       <= 1'b0;
        end else begin
            lock_flag <= lock_r;
            irq       <= |(irq_stat_r & irq_mask_r);
            rdata     <= '0;
            if (rd) begin
                case (addr)
                    OFS_LOCK_CFG: rdata <= lock_detect_config_r;
                    OFS_CP_GAIN:  rdata <= charge_pump_gain_offset_r;
                    OFS_PD_CFG:   rdata <= phase_detector_config_r;
                    OFS_STATUS:   rdata <= {{(DATA_W-2){1'b0}}, lock_r, w.open};
                    OFS_IRQ_STAT: rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
                    OFS_IRQ_MASK: rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
                    default:      rdata <= '0;
                endcase
            end
        end
    end
endmodule

//--- bench/pd_lock_detect_control_sva.sv
/*
 * port checker for pd_lock_detect_control, bound to every instance.
 * assumes one clock and the plain strobe register port.
 */
`timescale 1ns/10ps
module pd_lock_detect_control_sva
    import pdld_pkg::*;
(
    input wire logic              clk,              // clock
    input wire logic              resetn,           // reset, low
    input wire logic [ADDR_W-1:0] addr,             // address
    input wire logic [DATA_W-1:0] wdata,            // write data
    input wire logic              wr,               // write
    input wire logic              rd,               // read
    input wire logic [DATA_W-1:0] rdata,            // read data
    input wire logic              ref_edge,         // ref pin
    input wire logic              vco_edge,         // vco pin
    input wire logic              lock_flag,        // lock
    input wire logic              pump_up,          // pump up
    input wire logic              pump_dn,          // pump down
    input wire logic              pump_hiz,         // tri-state
    input wire logic [6:0]        pump_up_gain,     // up gain
    input wire logic [6:0]        pump_dn_gain,     // down gain
    input wire logic [6:0]        ofs_mag,          // offset
    input wire logic              ofs_up_en,        // up offset
    input wire logic              ofs_dn_en,        // down offset
    input wire logic              cycle_slip_guard, // boost
    input wire logic              irq               // interrupt
);
    logic [23:0] cp_w_r;    // last pump word written
    logic [23:0] pd_w_r;    // last detector word written
    logic [15:0] vco_cnt_r; // vco rises while unlocked
    logic        vco_d_r;   // vco pin delayed

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // shadows of the written pump and detector configuration words
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cp_w_r <= CP_GAIN_RST;
            pd_w_r <= PD_CFG_RST;
        end else if (wr && addr == OFS_CP_GAIN) begin
            cp_w_r <= wdata;
        end else if (wr && addr == OFS_PD_CFG) begin
            pd_w_r <= wdata;
        end
    end

    // count vco arrivals since the flag was last high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vco_d_r   <= 1'b0;
            vco_cnt_r <= 16'h0000;
        end else begin
            vco_d_r <= vco_edge;
            if (lock_flag) begin
                vco_cnt_r <= 16'h0000;
            end else if (vco_edge && !vco_d_r && vco_cnt_r != 16'hFFFF) begin
                vco_cnt_r <= vco_cnt_r + 16'h0001;
            end
        end
    end

    sequence s_cp_wr;
        wr && addr == OFS_CP_GAIN ##1 !(wr && addr == OFS_CP_GAIN);
    endsequence
    sequence s_pd_wr;
        wr && addr == OFS_PD_CFG ##1 !(wr && addr == OFS_PD_CFG);
    endsequence

    property p_rdata_idle;
        !$past(rd) |-> rdata == 24'h000000;
    endproperty
    property p_rd_unmapped;
        rd && addr == 8'h20 |=> rdata == 24'h000000;
    endproperty
    property p_rd_cp;
        rd && addr == OFS_CP_GAIN |=> rdata == cp_w_r;
    endproperty
    property p_gain;
        s_cp_wr |-> ##1 pump_up_gain == cp_w_r[13:7] && pump_dn_gain == cp_w_r[6:0];
    endproperty
    property p_ofs;
        s_cp_wr |-> ##1 {ofs_dn_en, ofs_up_en, ofs_mag} == cp_w_r[22:14];
    endproperty
    property p_hiz;
        s_pd_wr |-> ##1 pump_hiz == (pd_w_r[6:5] == 2'b00);
    endproperty
    property p_irq_mask;
        wr && addr == OFS_IRQ_MASK && wdata[1:0] == 2'b00 ##1 !wr |-> ##1 !irq;
    endproperty
    property p_lock_en;
        wr && addr == OFS_LOCK_CFG && !wdata[LK_EN_BIT] |-> ##3 !lock_flag [*4];
    endproperty
    property p_lock_count;
        $rose(lock_flag) |-> vco_cnt_r >= LKCNT_BASE;
    endproperty

    a_rdata_idle:  assert property (p_rdata_idle)  else $error("rdata not zero");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    a_rd_cp:       assert property (p_rd_cp)       else $error("pump word read");
    a_gain:        assert property (p_gain)        else $error("gain out");
    a_ofs:         assert property (p_ofs)         else $error("offset out");
    a_hiz:         assert property (p_hiz)         else $error("tri-state");
    a_irq_mask:    assert property (p_irq_mask)    else $error("masked irq");
    a_lock_en:     assert property (p_lock_en)     else $error("lock off");
    a_lock_count:  assert property (p_lock_count)  else $error("early lock");
endmodule

bind pd_lock_detect_control pd_lock_detect_control_sva u_sva (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ref_edge(ref_edge), .vco_edge(vco_edge), .lock_flag(lock_flag),
    .pump_up(pump_up), .pump_dn(pump_dn), .pump_hiz(pump_hiz),
    .pump_up_gain(pump_up_gain), .pump_dn_gain(pump_dn_gain), .ofs_mag(ofs_mag),
    .ofs_up_en(ofs_up_en), .ofs_dn_en(ofs_dn_en),
    .cycle_slip_guard(cycle_slip_guard), .irq(irq)
);

//--- bench/pd_lock_detect_control_tb.sv
/*
 * self-checking bench for pd_lock_detect_control with a lock model.
 * assumes the checker file is compiled beside it.
 */
`timescale 1ns/10ps
module pd_lock_detect_control_tb
    import pdld_pkg::*;
;
    logic        clk, resetn, wr, rd, ref_edge, vco_edge, irq;
    logic [7:0]  addr;
    logic [23:0] wdata, rdata, lk_m;
    logic        lock_flag, pump_up, pump_dn, pump_hiz, ofs_up_en, ofs_dn_en;
    logic        cycle_slip_guard;
    logic [6:0]  pump_up_gain, pump_dn_gain, ofs_mag;
    int          fail_count, n_compared, hits_m, win_m, seed;
    bit          lock_m, csg_s, up_s, dn_s;
    logic [1:0]  ist_m, msk_m;

    pd_lock_detect_control dut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ref_edge(ref_edge), .vco_edge(vco_edge), .lock_flag(lock_flag),
        .pump_up(pump_up), .pump_dn(pump_dn), .pump_hiz(pump_hiz),
        .pump_up_gain(pump_up_gain), .pump_dn_gain(pump_dn_gain), .ofs_mag(ofs_mag),
        .ofs_up_en(ofs_up_en), .ofs_dn_en(ofs_dn_en),
        .cycle_slip_guard(cycle_slip_guard), .irq(irq)
    );

    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one write cycle, strobe dropped at the next edge
    task automatic wr_reg(logic [7:0] a, logic [23:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // one read cycle, data checked in the following cycle
    task automatic rd_chk(string what, logic [7:0] a, logic [23:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(what, rdata, exp);
    endtask

    // one arrival pair; the model judges it against the window
    // runs on until a window opened by a late edge has expired
    task automatic pair(int off, bit vfirst);
        @(posedge clk);
        if (vfirst) vco_edge <= 1'b1;
        else ref_edge <= 1'b1;
        {csg_s, up_s, dn_s} = 3'b000;
        for (int i = 0; i < off + win_m + 24; i++) begin
            @(posedge clk);
            #1;
            csg_s |= cycle_slip_guard === 1'b1;
            up_s |= pump_up === 1'b1;
            dn_s |= pump_dn === 1'b1;
            if (i == off - 1) ref_edge <= 1'b1;
            if (i == off - 1) vco_edge <= 1'b1;
            if (i == off + 8) {ref_edge, vco_edge} <= 2'b00;
        end
        if (lk_m[LK_EN_BIT] && off >= win_m) begin
            if (lock_m) ist_m[IRQ_UNLK_BIT] = 1'b1;
            hits_m = 0;
            lock_m = 1'b0;
        end else if (lk_m[LK_EN_BIT] && ++hits_m >= (LKCNT_BASE << lk_m[2:0]) && !lock_m) begin
            ist_m[IRQ_LOCK_BIT] = 1'b1;
            lock_m = 1'b1;
        end
        check("lock_flag", lock_flag, lock_m);
        check("irq", irq, |(ist_m & msk_m));
    endtask

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        logic [23:0] d;
        int          spd;
        seed = 32'h9e0ae2f9;
        {resetn, wr, rd, ref_edge, vco_edge} = 5'b00000;
        addr = 8'h00;
        wdata = 24'h000000;
        {hits_m, lock_m, ist_m, msk_m, lk_m} = '0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // reset values and unmapped space
        rd_chk("lock_cfg", OFS_LOCK_CFG, LOCK_CFG_RST);
        rd_chk("cp_cfg", OFS_CP_GAIN, CP_GAIN_RST);
        rd_chk("pd_cfg", OFS_PD_CFG, PD_CFG_RST);
        check("pump_hiz", pump_hiz, 1'b0);
        wr_reg(8'h20, 24'hFFFFFF);
        rd_chk("unmapped", 8'h20, 24'h000000);
        // random gain and offset words
        repeat (6) begin
            d = 24'($random(seed)) & 24'h7FFFFF;
            if (d[22]) d[21] = 1'b0;
            wr_reg(OFS_CP_GAIN, d);
            rd_chk("cp_cfg", OFS_CP_GAIN, d);
            check("up_gain", pump_up_gain, d[13:7]);
            check("dn_gain", pump_dn_gain, d[6:0]);
            check("offset", {ofs_dn_en, ofs_up_en, ofs_mag}, d[22:14]);
        end
        // every pump enable pair
        for (int v = 0; v < 4; v++) begin
            wr_reg(OFS_PD_CFG, 24'(v << PD_UPEN_BIT));
            repeat (2) @(posedge clk);
            #1 check("pump_hiz", pump_hiz, v == 0);
        end
        wr_reg(OFS_IRQ_MASK, 24'h000003);
        msk_m = 2'b11;
        // divider codes 0..5 over all speeds; hits at half window
        for (int dv = 0; dv < 6; dv++) begin
            spd = (dv + 3) % 4;
            lk_m = 24'((1 << LK_EN_BIT) | (1 << LK_WTYPE_BIT) |
                       (dv << LK_DIV_LO) | (spd << LK_SPD_LO));
            win_m = (TICK_BASE + spd) << dv;
            wr_reg(OFS_LOCK_CFG, lk_m);
            repeat (65) pair(win_m / 2, 1'($random(seed)));
            pair(win_m + 6, 1'($random(seed)));
        end
        // sticky status, mask, clear
        rd_chk("irq_stat", OFS_IRQ_STAT, 24'(ist_m));
        wr_reg(OFS_IRQ_MASK, 24'h000000);
        repeat (2) @(posedge clk);
        #1 check("irq", irq, 1'b0);
        wr_reg(OFS_IRQ_MASK, 24'h000003);
        repeat (2) @(posedge clk);
        #1 check("irq", irq, |ist_m);
        wr_reg(OFS_IRQ_STAT, 24'h000003);
        ist_m = 2'b00;
        rd_chk("irq_stat", OFS_IRQ_STAT, 24'h000000);
        check("irq", irq, 1'b0);
        // slip threshold codes and polarity, 64 clock window
        lk_m = 24'((1 << LK_EN_BIT) | (1 << LK_WTYPE_BIT) | (5 << LK_DIV_LO));
        win_m = TICK_BASE << 5;
        wr_reg(OFS_LOCK_CFG, lk_m);
        for (int c = 0; c < 4; c++) begin
            wr_reg(OFS_PD_CFG, 24'(32'h60 | (c << PD_CSP_LO) | ((c & 1) << PD_POL_BIT)));
            pair(2, 1'b0);
            check("csp_short", csg_s, 1'b0);
            check("pump_dir", {up_s, dn_s}, (c & 1) ? 2'b01 : 2'b10);
            pair(win_m + 6, 1'b0);
            check("csp_long", csg_s, 1'b1);
        end
        // analog fixed window: lock on near-zero offset, then one late edge
        lk_m = 24'(1 << LK_EN_BIT);
        win_m = AWIN_CYC;
        wr_reg(OFS_LOCK_CFG, lk_m);
        repeat (64) pair(1, 1'b1);
        pair(AWIN_CYC + 6, 1'b1);
        // detection switched off: hits never lock
        lk_m[LK_EN_BIT] = 1'b0;
        wr_reg(OFS_LOCK_CFG, lk_m);
        repeat (66) pair(2, 1'($random(seed)));
        close_out();
    end
endmodule
